/* File: rtl/lpt_pkg.sv */
// Shared constants for the logic pattern trigger.
package lpt_pkg;

    // -------------------------------------------------------------------
    // Channel organisation
    // -------------------------------------------------------------------
    localparam int LPT_NUM_CH = 16;
    localparam int LPT_GRP_SIZE = 4;
    localparam int LPT_DUR_W = 28;
    localparam int LPT_THR_W = 12;

    // -------------------------------------------------------------------
    // Channel roles, two bits per channel
    // -------------------------------------------------------------------
    localparam logic [1:0] LPT_ROLE_DONT_CARE = 2'h0;
    localparam logic [1:0] LPT_ROLE_HIGH = 2'h1;
    localparam logic [1:0] LPT_ROLE_LOW = 2'h2;
    localparam logic [1:0] LPT_ROLE_CLOCK = 2'h3;

    // -------------------------------------------------------------------
    // Clock transition selection (code 3 behaves as either edge)
    // -------------------------------------------------------------------
    localparam logic [1:0] LPT_EDGE_RISING = 2'h0;
    localparam logic [1:0] LPT_EDGE_FALLING = 2'h1;
    localparam logic [1:0] LPT_EDGE_EITHER = 2'h2;

    // -------------------------------------------------------------------
    // Timing conditions when no clock channel exists
    // -------------------------------------------------------------------
    localparam logic [2:0] LPT_WHEN_GOES_TRUE = 3'h0;
    localparam logic [2:0] LPT_WHEN_GOES_FALSE = 3'h1;
    localparam logic [2:0] LPT_PATTERN_LONGER_CONDITION = 3'h2;
    localparam logic [2:0] LPT_PATTERN_SHORTER_CONDITION = 3'h3;
    localparam logic [2:0] LPT_PATTERN_EQUAL_CONDITION = 3'h4;
    localparam logic [2:0] LPT_PATTERN_UNEQUAL_CONDITION = 3'h5;

    // -------------------------------------------------------------------
    // Duration limits and tolerance
    // -------------------------------------------------------------------
    localparam longint LPT_CLK_PERIOD_NS = 40;
    localparam longint LPT_DUR_MIN_NS = 10;
    localparam longint LPT_DUR_MAX_NS = 64'd9990000000;
    localparam longint LPT_DUR_MIN_RAW = (LPT_DUR_MIN_NS + LPT_CLK_PERIOD_NS - 1) / LPT_CLK_PERIOD_NS;
    localparam longint LPT_DUR_MIN_CYC = (LPT_DUR_MIN_RAW < 1) ? 1 : LPT_DUR_MIN_RAW;
    localparam longint LPT_DUR_MAX_CYC = LPT_DUR_MAX_NS / LPT_CLK_PERIOD_NS;
    localparam logic [7:0] LPT_TOL_PCT = 8'h05;
    localparam logic [7:0] LPT_PCT_FULL = 8'h64;

    // -------------------------------------------------------------------
    // Threshold setting: bit 11 selects user level, low bits a preset
    // -------------------------------------------------------------------
    localparam int LPT_THR_USER_BIT = 11;
    localparam logic [2:0] LPT_THR_PRESET_TTL = 3'h0;
    localparam logic [LPT_THR_W-1:0] LPT_THR_RESET = {9'h000, LPT_THR_PRESET_TTL};

endpackage

/* File: rtl/lpt_trigger.sv */
// Logic pattern trigger over the digital input channels.
`timescale 1ns/100ps
// Overview of operation
// - Each channel is given one role: must be high, must be low, don't care, or clock.
// - With a clock channel present, the pattern is judged only at that clock's transitions.
// - Without a clock channel, the trigger comes from a timing condition on the pattern-true signal.
// - Goes-true fires on the rising edge of pattern-true.
// - Goes-false fires on the falling edge of pattern-true.
// - Longer-than fires at the falling edge if the true time exceeded the duration (10.0ns to 9.99s).
// - Shorter-than fires at the falling edge if the true time was below the duration.
// - Equal fires at the falling edge if the true time was within five percent of the duration.
// - Not-equal fires at the falling edge if the true time was outside five percent of the duration.
// - Input thresholds are held per group of four channels, each a preset or user level.
// - One threshold per group is shared with logic analysis; a trigger-side write overrides it.
module lpt_trigger
    import lpt_pkg::*;
#(
    parameter int NCH = LPT_NUM_CH,
    parameter int DUR_W = LPT_DUR_W,
    parameter logic [DUR_W-1:0] DUR_MAX_CYC = DUR_W'(LPT_DUR_MAX_CYC)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Channel pins, asynchronous to clk_i
    input wire logic [NCH-1:0] ch_i,
    // Pattern configuration
    input wire logic [2*NCH-1:0] role_i,
    input wire logic [1:0] clk_edge_i,
    input wire logic [2:0] when_i,
    input wire logic [DUR_W-1:0] dur_cyc_i,
    // Threshold writes from the trigger side and the analysis side
    input wire logic thr_trig_we_i,
    input wire logic [$clog2(NCH/LPT_GRP_SIZE)-1:0] thr_trig_grp_i,
    input wire logic thr_an_we_i,
    input wire logic [$clog2(NCH/LPT_GRP_SIZE)-1:0] thr_an_grp_i,
    input wire logic [LPT_THR_W-1:0] thr_val_i,
    // Results
    output logic trig_o,
    output logic pattern_true_o,
    output logic clocked_mode_o,
    output logic [DUR_W-1:0] true_len_o,
    output logic [(NCH/LPT_GRP_SIZE)*LPT_THR_W-1:0] thr_o
);

    // -------------------------------------------------------------------
    // Types and local constants
    // -------------------------------------------------------------------
    localparam int NGRP = NCH / LPT_GRP_SIZE;
    localparam int IDX_W = $clog2(NCH);
    localparam int PROD_W = DUR_W + 8;

    typedef struct packed {
        logic [NCH-1:0] s1;
        logic [NCH-1:0] s2;
        logic [NCH-1:0] s3;
        logic [NCH-1:0] filt;
        logic clkv;
        logic pt;
        logic [DUR_W-1:0] cnt;
        logic trig;
        logic clocked;
        logic [NGRP-1:0][LPT_THR_W-1:0] thr;
    } lpt_state_t;

    localparam lpt_state_t ST_RESET = '{thr: {NGRP{LPT_THR_RESET}}, default: '0};

    // -------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------
    // Lowest-numbered clock channel wins if several are marked.
    function automatic logic [IDX_W:0] clk_find(input logic [2*NCH-1:0] roles);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (roles[2*i +: 2] == LPT_ROLE_CLOCK) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    // Don't-care and clock channels never spoil the match.
    function automatic logic pattern_match(input logic [NCH-1:0] lv, input logic [2*NCH-1:0] roles);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < NCH; i++) begin
            if (roles[2*i +: 2] == LPT_ROLE_HIGH && !lv[i]) begin
                ok = 1'b0;
            end else if (roles[2*i +: 2] == LPT_ROLE_LOW && lv[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // True when len lies within the tolerance band around dur.
    function automatic logic within_tol(input logic [DUR_W-1:0] len, input logic [DUR_W-1:0] dur);
        logic [PROD_W-1:0] l100;
        logic [PROD_W-1:0] lo;
        logic [PROD_W-1:0] hi;
        l100 = PROD_W'(len) * PROD_W'(LPT_PCT_FULL);
        lo = PROD_W'(dur) * PROD_W'(LPT_PCT_FULL - LPT_TOL_PCT);
        hi = PROD_W'(dur) * PROD_W'(LPT_PCT_FULL + LPT_TOL_PCT);
        return (l100 >= lo) && (l100 <= hi);
    endfunction

    // -------------------------------------------------------------------
    // State and derived signals
    // -------------------------------------------------------------------
    lpt_state_t st_reg;
    lpt_state_t st_next;
    logic [IDX_W:0] clk_sel;
    logic clk_found;
    logic cur_clk;
    logic clk_rise;
    logic clk_fall;
    logic sel_edge;
    logic pat_now;
    logic pt_rise;
    logic pt_fall;
    logic [DUR_W-1:0] dur_eff;
    logic [NCH-1:0] agree;

    // Role decode and clock channel lookup.
    assign clk_sel = clk_find(role_i);
    assign clk_found = clk_sel[IDX_W];
    assign cur_clk = st_reg.filt[clk_sel[IDX_W-1:0]];
    assign clk_rise = cur_clk & ~st_reg.clkv;
    assign clk_fall = ~cur_clk & st_reg.clkv;

    // Edge selection; the unused code 3 falls back to either edge.
    always_comb begin
        if (!clk_found) begin
            sel_edge = 1'b0;
        end else if (clk_edge_i == LPT_EDGE_RISING) begin
            sel_edge = clk_rise;
        end else if (clk_edge_i == LPT_EDGE_FALLING) begin
            sel_edge = clk_fall;
        end else begin
            sel_edge = clk_rise | clk_fall;
        end
    end

    // Pattern evaluation on the filtered levels.
    assign pat_now = pattern_match(st_reg.filt, role_i);
    assign pt_rise = pat_now & ~st_reg.pt;
    assign pt_fall = ~pat_now & st_reg.pt;

    // Out-of-range durations are clamped so the comparison always has a legal target.
    assign dur_eff = (dur_cyc_i < DUR_W'(LPT_DUR_MIN_CYC)) ? DUR_W'(LPT_DUR_MIN_CYC) :
                     (dur_cyc_i > DUR_MAX_CYC) ? DUR_MAX_CYC : dur_cyc_i;
    assign agree = ~(st_reg.s2 ^ st_reg.s3);

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Three-stage pin synchroniser; a level counts once stages two and three agree.
        st_next.s1 = ch_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.filt = (st_reg.s3 & agree) | (st_reg.filt & ~agree);
        st_next.clkv = cur_clk;
        st_next.pt = pat_now;
        st_next.clocked = clk_found;
        // The counter saturates so a very long true interval still reads as long.
        if (pt_rise) begin
            st_next.cnt = DUR_W'(1);
        end else if (pat_now && st_reg.cnt != {DUR_W{1'b1}}) begin
            st_next.cnt = st_reg.cnt + DUR_W'(1);
        end
        // Trigger decision.
        if (clk_found) begin
            st_next.trig = sel_edge & pat_now;
        end else begin
            case (when_i)
                LPT_WHEN_GOES_TRUE: begin
                    st_next.trig = pt_rise;
                end
                LPT_WHEN_GOES_FALSE: begin
                    st_next.trig = pt_fall;
                end
                LPT_PATTERN_LONGER_CONDITION: begin
                    st_next.trig = pt_fall && (st_reg.cnt > dur_eff);
                end
                LPT_PATTERN_SHORTER_CONDITION: begin
                    st_next.trig = pt_fall && (st_reg.cnt < dur_eff);
                end
                LPT_PATTERN_EQUAL_CONDITION: begin
                    st_next.trig = pt_fall && within_tol(st_reg.cnt, dur_eff);
                end
                LPT_PATTERN_UNEQUAL_CONDITION: begin
                    st_next.trig = pt_fall && !within_tol(st_reg.cnt, dur_eff);
                end
                default: begin
                    st_next.trig = 1'b0;
                end
            endcase
        end
        // One shared threshold per group; the trigger write is applied last so it wins.
        if (thr_an_we_i) begin
            st_next.thr[thr_an_grp_i] = thr_val_i;
        end
        if (thr_trig_we_i) begin
            st_next.thr[thr_trig_grp_i] = thr_val_i;
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign trig_o = st_reg.trig;
    assign pattern_true_o = st_reg.pt;
    assign clocked_mode_o = st_reg.clocked;
    assign true_len_o = st_reg.cnt;
    assign thr_o = st_reg.thr;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_pattern_roles: assert property (pattern_true_o == $past(pattern_match(st_reg.filt, role_i)))
        else $error("pattern-true does not follow the channel roles");

    a_clocked_fire: assert property (sel_edge && pat_now |=> trig_o)
        else $error("selected clock edge with true pattern gave no trigger");

    a_clocked_quiet: assert property (clk_found && !sel_edge |=> !trig_o)
        else $error("trigger fired in clocked mode without a selected edge");

    a_unclocked_edge: assert property (trig_o && !clocked_mode_o |-> pattern_true_o != $past(pattern_true_o))
        else $error("unclocked trigger without a pattern-true transition");

    a_goes_true: assert property ($rose(pattern_true_o) && $past(!clk_found && when_i == LPT_WHEN_GOES_TRUE)
                                  |-> trig_o)
        else $error("goes-true condition missed a rising pattern");

    a_goes_false: assert property ($fell(pattern_true_o) && $past(!clk_found && when_i == LPT_WHEN_GOES_FALSE)
                                   |-> trig_o)
        else $error("goes-false condition missed a falling pattern");

    a_longer_len: assert property (trig_o && $past(!clk_found && when_i == LPT_PATTERN_LONGER_CONDITION)
                                   |-> $fell(pattern_true_o) && $past(st_reg.cnt) > $past(dur_eff))
        else $error("longer-than trigger with a short interval");

    a_shorter_len: assert property (trig_o && $past(!clk_found && when_i == LPT_PATTERN_SHORTER_CONDITION)
                                    |-> $fell(pattern_true_o) && $past(st_reg.cnt) < $past(dur_eff))
        else $error("shorter-than trigger with a long interval");

    a_equal_band: assert property ($fell(pattern_true_o) && $past(!clk_found && when_i == LPT_PATTERN_EQUAL_CONDITION)
                                   |-> trig_o == $past(within_tol(st_reg.cnt, dur_eff)))
        else $error("equal condition disagrees with the tolerance band");

    a_unequal_band: assert property ($fell(pattern_true_o) && $past(!clk_found && when_i == LPT_PATTERN_UNEQUAL_CONDITION)
                                     |-> trig_o != $past(within_tol(st_reg.cnt, dur_eff)))
        else $error("not-equal condition disagrees with the tolerance band");

    a_count_restart: assert property ($rose(pattern_true_o) |-> true_len_o == DUR_W'(1) ##1
                                      (!pattern_true_o || true_len_o == DUR_W'(2)))
        else $error("true-interval counter did not restart and advance");

    a_thr_override: assert property (thr_trig_we_i |=> st_reg.thr[$past(thr_trig_grp_i)] == $past(thr_val_i))
        else $error("trigger threshold write did not take the group");

    // An analysis-side write lands unless the trigger side wrote the same group.
    a_thr_analysis: assert property (thr_an_we_i && !(thr_trig_we_i && thr_trig_grp_i == thr_an_grp_i)
                                     |=> st_reg.thr[$past(thr_an_grp_i)] == $past(thr_val_i))
        else $error("analysis threshold write did not take the group");

    // Without any write the group thresholds must not move.
    a_thr_hold: assert property (!thr_an_we_i && !thr_trig_we_i |=> $stable(thr_o))
        else $error("group thresholds changed without a write");

    // The mode flag reports whether any channel held the clock role one cycle earlier.
    a_mode_flag: assert property (!$past(rst_i) |-> clocked_mode_o == $past(clk_found))
        else $error("clocked-mode flag does not follow the channel roles");

    // Unused condition codes must never produce a trigger in unclocked mode.
    a_unused_when: assert property (!clk_found && when_i > LPT_PATTERN_UNEQUAL_CONDITION
                                    |=> !trig_o)
        else $error("trigger fired under an unused timing condition");

    // While the pattern is false the interval counter keeps the last length.
    a_len_hold: assert property (!pat_now |=> true_len_o == $past(true_len_o))
        else $error("interval counter moved while the pattern was false");

endmodule

/* File: verification/lpt_pin_src.sv */
// Far-side source that drives the logic input channels.
`timescale 1ns/100ps
module lpt_pin_src
    import lpt_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Channel pins
    output logic [LPT_NUM_CH-1:0] ch_o
);
    // Levels change just after a falling edge and stay for at least two cycles, so the input filter never drops one.
    task automatic drive(input logic [LPT_NUM_CH-1:0] lv, input int n);
        @(negedge clk_i);
        ch_o = lv;
        repeat ((n < 2) ? 1 : n - 1) @(negedge clk_i);
    endtask

    // Pins start low.
    initial begin
        ch_o = '0;
    end
endmodule

/* File: verification/lpt_trigger_tb.sv */
// Self-checking bench for the logic pattern trigger.
`timescale 1ns/100ps
module lpt_trigger_tb;
    import lpt_pkg::*;
    localparam int DMAX = 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] ch_i;
    logic [31:0] role_i = 32'h40000000;
    logic [1:0] clk_edge_i = 2'h0;
    logic [2:0] when_i = 3'h0;
    logic [27:0] dur_cyc_i = 28'h0000014;
    logic thr_trig_we_i = 1'b0;
    logic thr_an_we_i = 1'b0;
    logic [1:0] thr_trig_grp_i = 2'h0;
    logic [1:0] thr_an_grp_i = 2'h0;
    logic [11:0] thr_val_i = 12'h000;
    logic trig_o, pattern_true_o, clocked_mode_o;
    logic [27:0] true_len_o;
    logic [47:0] thr_o;
    logic [15:0] s1, s2, s3, flt, flt_d, v;
    logic [11:0] m_thr [4];
    logic [31:0] r;
    logic m_pt, m_trig, m_cm, pn, t, q;
    int seed = 32'h167f;
    int n_fail = 0;
    int cmp_count = 0;
    int m_len, c, d, j, w, e;
    int lens [12] = '{2, 3, 18, 19, 20, 21, 22, 40, 198, 199, 201, 205};
    int durs [3] = '{20, 0, 300};

    // 25 MHz clock.
    always #20 clk_i = ~clk_i;

    lpt_pin_src src (.clk_i(clk_i), .ch_o(ch_i));
    lpt_trigger #(.DUR_MAX_CYC(28'(DMAX))) uut (.clk_i(clk_i), .rst_i(rst_i), .ch_i(ch_i), .role_i(role_i),
        .clk_edge_i(clk_edge_i), .when_i(when_i), .dur_cyc_i(dur_cyc_i), .thr_trig_we_i(thr_trig_we_i),
        .thr_trig_grp_i(thr_trig_grp_i), .thr_an_we_i(thr_an_we_i), .thr_an_grp_i(thr_an_grp_i),
        .thr_val_i(thr_val_i), .trig_o(trig_o), .pattern_true_o(pattern_true_o),
        .clocked_mode_o(clocked_mode_o), .true_len_o(true_len_o), .thr_o(thr_o));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Reference model
    // -------------------------------------------------------------------
    // Mirrors the three-stage pin filter so results line up cycle for cycle with the design.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {s1, s2, s3, flt, flt_d} = '0;
            {m_pt, m_trig, m_cm} = 3'h0;
            m_len = 0;
            foreach (m_thr[g]) m_thr[g] = LPT_THR_RESET;
        end else begin
            c = -1;
            pn = 1'b1;
            for (j = 15; j >= 0; j--) begin
                if (role_i[2*j +: 2] == LPT_ROLE_CLOCK) c = j;
                if (role_i[2*j +: 2] == LPT_ROLE_HIGH && !flt[j]) pn = 1'b0;
                if (role_i[2*j +: 2] == LPT_ROLE_LOW && flt[j]) pn = 1'b0;
            end
            d = (dur_cyc_i == 0) ? 1 : ((dur_cyc_i > DMAX) ? DMAX : int'(dur_cyc_i));
            q = (95 * d <= 100 * m_len) && (100 * m_len <= 105 * d);
            case (when_i)
                LPT_WHEN_GOES_TRUE: t = pn && !m_pt;
                LPT_WHEN_GOES_FALSE: t = m_pt && !pn;
                LPT_PATTERN_LONGER_CONDITION: t = m_pt && !pn && m_len > d;
                LPT_PATTERN_SHORTER_CONDITION: t = m_pt && !pn && m_len < d;
                LPT_PATTERN_EQUAL_CONDITION: t = m_pt && !pn && q;
                LPT_PATTERN_UNEQUAL_CONDITION: t = m_pt && !pn && !q;
                default: t = 1'b0;
            endcase
            if (c >= 0) begin
                t = pn && (flt[c] != flt_d[c]) &&
                    ((clk_edge_i == LPT_EDGE_RISING) ? flt[c] : ((clk_edge_i == LPT_EDGE_FALLING) ? !flt[c] : 1'b1));
            end
            m_len = pn ? (m_pt ? m_len + 1 : 1) : m_len;
            m_trig = t;
            m_pt = pn;
            m_cm = (c >= 0);
            flt_d = flt;
            flt = (flt & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
            s3 = s2;
            s2 = s1;
            s1 = ch_i;
            if (thr_an_we_i) m_thr[thr_an_grp_i] = thr_val_i;
            if (thr_trig_we_i) m_thr[thr_trig_grp_i] = thr_val_i;
        end
    end

    // Every result is compared each cycle, during reset too.
    always @(negedge clk_i) begin
        chk(48'(trig_o), 48'(m_trig));
        chk(48'(pattern_true_o), 48'(m_pt));
        chk(48'(clocked_mode_o), 48'(m_cm));
        chk(48'(true_len_o), 48'(m_len));
        chk(thr_o, {m_thr[3], m_thr[2], m_thr[1], m_thr[0]});
    end

    // Pin levels that satisfy the current roles, with don't-care pins random.
    function automatic logic [15:0] good();
        logic [15:0] g;
        g = 16'($random(seed));
        for (int b = 0; b < 16; b++) begin
            if (role_i[2*b +: 2] == LPT_ROLE_HIGH) g[b] = 1'b1;
            if (role_i[2*b +: 2] == LPT_ROLE_LOW) g[b] = 1'b0;
        end
        return g;
    endfunction

    // Roles change only while all pins are low; channel 15 must be high, so the pattern stays false meanwhile.
    task automatic cfg(input int ck, input int sel);
        src.drive(16'h0000, 5);
        for (int b = 0; b < 16; b++) begin
            r = $random(seed);
            role_i[2*b +: 2] = (r[1:0] == LPT_ROLE_CLOCK) ? LPT_ROLE_DONT_CARE : r[1:0];
        end
        role_i[31:30] = LPT_ROLE_HIGH;
        if (ck != 0) role_i[1:0] = LPT_ROLE_CLOCK;
        when_i = 3'(sel);
        clk_edge_i = 2'(sel);
        src.drive(16'h0000, 4);
    endtask

    // Watchdog against a hang.
    initial begin
        #(40 * 60000);
        n_fail++;
        test_done();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (40) begin
            @(negedge clk_i);
            r = $random(seed);
            thr_trig_we_i = r[0];
            thr_an_we_i = r[1];
            thr_trig_grp_i = r[3:2];
            thr_an_grp_i = r[5:4];
            thr_val_i = r[17:6];
        end
        @(negedge clk_i);
        thr_trig_we_i = 1'b0;
        thr_an_we_i = 1'b0;
        for (w = 0; w < 8; w++) begin
            cfg(0, w);
            foreach (durs[k]) begin
                dur_cyc_i = 28'(durs[k]);
                foreach (lens[i]) begin
                    src.drive(good(), lens[i]);
                    v = good();
                    v[15] = 1'b0;
                    r = $random(seed);
                    src.drive(v, 2 + int'(r[1:0]));
                end
            end
        end
        for (e = 0; e < 4; e++) begin
            cfg(1, e);
            repeat (60) begin
                r = $random(seed);
                v = r[0] ? good() : r[31:16];
                v[0] = ch_i[0] ^ (r[1] | r[2]);
                src.drive(v, 2 + int'(r[3]));
            end
        end
        test_done();
    end
endmodule
